/* smc_down_counter.sv */
// Loadable down counter with a one-cycle expiry flag
`timescale 1ns/1ps
`default_nettype none
module smc_down_counter #(
  parameter int W = 17
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              busy,
  output logic              done
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic [W-1:0] one;

  assign one      = {{(W-1){1'b0}}, 1'b1};
  assign busy     = (cnt_reg != '0);
  assign done     = busy && (cnt_reg == one) && !load;
  assign cnt_next = load ? load_val : (busy ? cnt_reg - one : cnt_reg);

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule
`default_nettype wire

/* smc_irq_model.sv */
// Interrupt source model facing the standby controller wake inputs
`timescale 1ns/1ps
`default_nettype none
module smc_irq_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       go_nmi,
  input  wire logic       go_ext,
  input  wire logic       go_irq,
  input  wire logic       hold,
  input  wire logic [2:0] lvl,
  input  wire logic       served,
  output logic            nmi_req,
  output logic            ext_wake,
  output logic [2:0]      ext_level,
  output logic            irq_valid,
  output logic [2:0]      irq_level
);
  // ==========================================================================
  // Request lines
  // Level pins stay up until answered, as a level wake pin must;
  // hold low gives a one-cycle glitch instead
  always_ff @(posedge clk) begin
    if (rst) begin
      nmi_req   <= 1'b0;
      ext_wake  <= 1'b0;
      irq_valid <= 1'b0;
      ext_level <= 3'h0;
      irq_level <= 3'h0;
    end else begin
      nmi_req   <= go_nmi | (nmi_req & hold & ~served);
      ext_wake  <= go_ext | (ext_wake & hold & ~served);
      irq_valid <= go_irq | (irq_valid & hold & ~served);
      if (go_ext) ext_level <= lvl;
      if (go_irq) irq_level <= lvl;
    end
  end
endmodule
`default_nettype wire

/* smc_pkg.sv */
// Constants, types and register layout of the standby mode controller
//
// Behaviour
// - Halt instruction enters the state chosen by the standby field; 00 halt, 01 stop.
// - CPU-only halt stops execution; peripherals and oscillator keep running.
// - Idle keeps only the oscillator running; CPU and peripherals stop.
// - Full stop halts every internal circuit including the oscillator.
// - Interrupt wake from stop waits 2^14 or 2^16 oscillator periods first.
// - Idle or stop is left only by reset, non-maskable or external pin.
// - Pin wake arriving during the three-clock entry is held pending.
// - On wake with a pending request, higher priority is serviced first.
// - In halt, request level at least the mask ends halt with interrupt processing.
// - In halt, with mask above level, only the external pin resumes execution.
// - Idle or stop wakes on non-maskable or external pin, then interrupt processing.
// - Drive bit clear floats outputs in stop; set keeps outputs driving.
// - Enabled output-function pins pick pull direction from function data in stop.
// - Input-function pins pick pull direction from the port register only.
// - Input-gate-disabled pins switch their input gate off in stop.
package smc_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] ADDR_MODE   = 8'h5C;
  localparam logic [7:0] ADDR_STATUS = 8'h60;
  localparam logic [7:0] MODE_RESET  = 8'h80;

  localparam int BIT_WDOG_EN    = 7;
  localparam int BIT_WDOG_PER_H = 6;
  localparam int BIT_WDOG_PER_L = 5;
  localparam int BIT_WARM       = 4;
  localparam int BIT_SEL_HI     = 3;
  localparam int BIT_SEL_LO     = 2;
  localparam int BIT_RST_LINK   = 1;
  localparam int BIT_DRIVE      = 0;

  // ==========================================================================
  // Standby field encodings
  localparam logic [1:0] SEL_HALT = 2'h0;
  localparam logic [1:0] SEL_STOP = 2'h1;
  localparam logic [1:0] SEL_IDLE = 2'h2;

  // ==========================================================================
  // Timing, oscillator periods equal core clock periods
  localparam int unsigned CLK_HZ             = 10_000_000;
  localparam int unsigned OSC_HZ             = 10_000_000;
  localparam int unsigned WARM_SHORT_PERIODS = 16384;
  localparam int unsigned WARM_LONG_PERIODS  = 65536;
  localparam int unsigned ENTER_PERIODS      = 3;
  localparam int unsigned WARM_SHORT_CYCLES  = WARM_SHORT_PERIODS * (CLK_HZ / OSC_HZ);
  localparam int unsigned WARM_LONG_CYCLES   = WARM_LONG_PERIODS * (CLK_HZ / OSC_HZ);
  localparam int unsigned ENTER_CYCLES       = ENTER_PERIODS * (CLK_HZ / OSC_HZ);
  localparam int          CNT_W              = 17;
  localparam logic [2:0]  NMI_LEVEL          = 3'h7;
  localparam int          PINS               = 8;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    ST_RUN   = 3'b000,
    ST_ENTER = 3'b001,
    ST_HALT  = 3'b010,
    ST_IDLE  = 3'b011,
    ST_STOP  = 3'b100,
    ST_WARM  = 3'b101,
    ST_SVC1  = 3'b110,
    ST_SVC2  = 3'b111
  } smc_state_t;

  typedef struct packed {
    logic       nmi;
    logic [2:0] level;
  } smc_svc_t;

endpackage

/* smc_standby_ctrl.sv */
// Standby mode controller top: mode register, power state machine, pin states
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module smc_standby_ctrl #(
  parameter int unsigned WARM_SHORT = smc_pkg::WARM_SHORT_CYCLES,
  parameter int unsigned WARM_LONG  = smc_pkg::WARM_LONG_CYCLES
) (
  input  wire logic                    CORE_CLK,
  input  wire logic                    SYS_RST,
  input  wire logic                    PSEL,
  input  wire logic                    PENABLE,
  input  wire logic                    PWRITE,
  input  wire logic [7:0]              PADDR,
  input  wire logic [31:0]             PWDATA,
  output logic      [31:0]             PRDATA,
  output logic                         PREADY,
  output logic                         PSLVERR,
  input  wire logic                    HALT_EXEC,
  input  wire logic                    IRQ_VALID,
  input  wire logic [2:0]              IRQ_LEVEL,
  input  wire logic                    NMI_REQ,
  input  wire logic                    EXT_WAKE,
  input  wire logic [2:0]              EXT_LEVEL,
  input  wire logic [2:0]              INT_MASK,
  output logic                         CPU_RUN_EN,
  output logic                         PERIPH_CLK_EN,
  output logic                         OSC_EN,
  output logic                         SYS_CLK_EN,
  output logic                         SVC_VALID,
  output smc_pkg::smc_svc_t            SVC,
  output logic                         RESUME,
  output logic                         WDOG_EN,
  output logic      [1:0]              WDOG_PERIOD,
  output logic                         WDOG_RST_LINK,
  input  wire logic [smc_pkg::PINS-1:0] PORT_DATA,
  input  wire logic [smc_pkg::PINS-1:0] PORT_DIR_OUT,
  input  wire logic [smc_pkg::PINS-1:0] PORT_LATCH,
  input  wire logic [smc_pkg::PINS-1:0] PIN_FUNC_SEL,
  input  wire logic [smc_pkg::PINS-1:0] FUNC_DATA,
  input  wire logic [smc_pkg::PINS-1:0] GATE_DIS_MASK,
  output logic      [smc_pkg::PINS-1:0] PIN_O,
  output logic      [smc_pkg::PINS-1:0] PIN_OE,
  output logic      [smc_pkg::PINS-1:0] PIN_PULL_UP,
  output logic      [smc_pkg::PINS-1:0] PIN_IN_GATE
);
  import smc_pkg::*;

  // ==========================================================================
  // Register bus
  logic [7:0]  mode_reg;
  logic        pready_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  logic        access;
  logic        wr_take;
  logic        hit_mode;
  logic        hit_status;
  logic [31:0] rd_mux;
  logic [7:0]  status_word;
  smc_state_t  state_reg;
  smc_state_t  state_next;
  logic        pend_valid_reg;
  logic        pend_valid_next;
  smc_svc_t    pend_reg;
  smc_svc_t    pend_next;
  smc_svc_t    cur_reg;
  smc_svc_t    cur_next;
  logic        stop_tgt_reg;
  logic        stop_tgt_next;

  // One wait state keeps every bus output straight from a flop
  assign access      = PSEL && PENABLE;
  assign wr_take     = access && pready_reg && PWRITE;
  assign hit_mode    = (PADDR == ADDR_MODE);
  assign hit_status  = (PADDR == ADDR_STATUS);
  assign status_word = {pend_reg.level, pend_reg.nmi, pend_valid_reg, state_reg};
  assign rd_mux      = hit_mode   ? {24'h00_0000, mode_reg} :
                       hit_status ? {24'h00_0000, status_word} : 32'h0000_0000;

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= access && !pready_reg;
      prdata_reg  <= rd_mux;
      pslverr_reg <= access && !pready_reg && !(hit_mode || hit_status);
    end
  end

  // Status register is read only; writes there are dropped
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      mode_reg <= MODE_RESET;
    end else if (wr_take && hit_mode) begin
      mode_reg <= PWDATA[7:0];
    end
  end

  assign PREADY  = pready_reg;
  assign PRDATA  = prdata_reg;
  assign PSLVERR = pslverr_reg;

  // ==========================================================================
  // Wake qualification
  logic [1:0]      sel;
  logic            halt_ok;
  logic            ext_ok;
  logic            stby_wake;
  smc_svc_t        halt_req;
  smc_svc_t        stby_req;
  logic            pend_first;
  smc_svc_t        first_svc;
  smc_svc_t        second_svc;
  logic            warm_load;
  logic            enter_load;
  logic            warm_done;
  logic            enter_done;
  logic [CNT_W-1:0] warm_val;

  assign sel    = {mode_reg[BIT_SEL_HI], mode_reg[BIT_SEL_LO]};
  assign ext_ok = EXT_WAKE && (EXT_LEVEL >= INT_MASK);
  assign halt_ok = NMI_REQ || ext_ok || (IRQ_VALID && (IRQ_LEVEL >= INT_MASK));
  assign halt_req = NMI_REQ ? smc_svc_t'{nmi: 1'b1, level: NMI_LEVEL} :
                    ext_ok  ? smc_svc_t'{nmi: 1'b0, level: EXT_LEVEL} :
                              smc_svc_t'{nmi: 1'b0, level: IRQ_LEVEL};
  // Only the two pins wake idle or stop
  assign stby_wake = NMI_REQ || ext_ok;
  assign stby_req  = NMI_REQ ? smc_svc_t'{nmi: 1'b1, level: NMI_LEVEL} :
                               smc_svc_t'{nmi: 1'b0, level: EXT_LEVEL};

  // Priority compare; the older request wins a tie
  assign pend_first = pend_valid_next && (pend_next.level >= cur_next.level);
  assign first_svc  = pend_first ? pend_next : cur_next;
  assign second_svc = pend_first ? cur_next : pend_next;

  // Warm-up length from the warm bit
  assign warm_val = mode_reg[BIT_WARM] ? CNT_W'(WARM_LONG) : CNT_W'(WARM_SHORT);

  smc_down_counter #(.W(CNT_W)) u_enter_cnt (
    .clk      (CORE_CLK),
    .rst      (SYS_RST),
    .load     (enter_load),
    .load_val (CNT_W'(ENTER_CYCLES)),
    .busy     (),
    .done     (enter_done)
  );

  smc_down_counter #(.W(CNT_W)) u_warm_cnt (
    .clk      (CORE_CLK),
    .rst      (SYS_RST),
    .load     (warm_load),
    .load_val (warm_val),
    .busy     (),
    .done     (warm_done)
  );

  // ==========================================================================
  // Power state machine
  logic resume_next;

  always_comb begin
    state_next      = state_reg;
    pend_valid_next = pend_valid_reg;
    pend_next       = pend_reg;
    cur_next        = cur_reg;
    stop_tgt_next   = stop_tgt_reg;
    resume_next     = 1'b0;
    warm_load       = 1'b0;
    enter_load      = 1'b0;
    unique case (state_reg)
      ST_RUN: begin
        if (HALT_EXEC) begin
          // Standby field decode; 11 acts as plain halt
          if (sel == SEL_STOP || sel == SEL_IDLE) begin
            state_next    = ST_ENTER;
            stop_tgt_next = (sel == SEL_STOP);
            enter_load    = 1'b1;
          end else begin
            state_next = ST_HALT;
          end
        end
      end
      ST_ENTER: begin
        // Pin event during entry is kept, not acted on
        if ((NMI_REQ || EXT_WAKE) && !pend_valid_reg) begin
          pend_valid_next = 1'b1;
          pend_next       = NMI_REQ ? smc_svc_t'{nmi: 1'b1, level: NMI_LEVEL} :
                                      smc_svc_t'{nmi: 1'b0, level: EXT_LEVEL};
        end
        if (enter_done) begin
          state_next = stop_tgt_reg ? ST_STOP : ST_IDLE;
        end
      end
      ST_HALT: begin
        if (halt_ok) begin
          cur_next   = halt_req;
          state_next = ST_SVC1;
        end else if (EXT_WAKE) begin
          // Masked pin resumes after the halt, no processing
          resume_next = 1'b1;
          state_next  = ST_RUN;
        end
      end
      ST_IDLE: begin
        if (stby_wake) begin
          cur_next   = stby_req;
          state_next = ST_SVC1;
        end
      end
      ST_STOP: begin
        if (stby_wake) begin
          // Clock stays off until warm-up expires
          cur_next   = stby_req;
          warm_load  = 1'b1;
          state_next = ST_WARM;
        end
      end
      ST_WARM: begin
        if (warm_done) begin
          state_next = ST_SVC1;
        end
      end
      ST_SVC1: begin
        state_next = pend_valid_reg ? ST_SVC2 : ST_RUN;
      end
      ST_SVC2: begin
        pend_valid_next = 1'b0;
        state_next      = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      state_reg      <= ST_RUN;
      pend_valid_reg <= 1'b0;
      pend_reg       <= '0;
      cur_reg        <= '0;
      stop_tgt_reg   <= 1'b0;
    end else begin
      state_reg      <= state_next;
      pend_valid_reg <= pend_valid_next;
      pend_reg       <= pend_next;
      cur_reg        <= cur_next;
      stop_tgt_reg   <= stop_tgt_next;
    end
  end

  // ==========================================================================
  // Enables and service outputs, registered from the next state
  logic            cpu_en_next;
  logic            per_en_next;
  logic            osc_en_next;
  logic            clk_en_next;
  logic            svc_valid_next;
  smc_svc_t        svc_next;
  logic            stop_pins;

  assign cpu_en_next    = (state_next == ST_RUN) || (state_next == ST_SVC1) ||
                          (state_next == ST_SVC2);
  assign per_en_next    = !((state_next == ST_IDLE) || (state_next == ST_STOP) ||
                            (state_next == ST_WARM));
  assign osc_en_next    = (state_next != ST_STOP);
  assign clk_en_next    = per_en_next;
  assign svc_valid_next = (state_next == ST_SVC1) || (state_next == ST_SVC2);
  assign svc_next       = (state_next == ST_SVC2) ? second_svc : first_svc;
  assign stop_pins      = (state_next == ST_STOP) || (state_next == ST_WARM);

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      CPU_RUN_EN    <= 1'b1;
      PERIPH_CLK_EN <= 1'b1;
      OSC_EN        <= 1'b1;
      SYS_CLK_EN    <= 1'b1;
      SVC_VALID     <= 1'b0;
      SVC           <= '0;
      RESUME        <= 1'b0;
    end else begin
      CPU_RUN_EN    <= cpu_en_next;
      PERIPH_CLK_EN <= per_en_next;
      OSC_EN        <= osc_en_next;
      SYS_CLK_EN    <= clk_en_next;
      SVC_VALID     <= svc_valid_next;
      SVC           <= svc_valid_next ? svc_next : '0;
      RESUME        <= resume_next;
    end
  end

  assign WDOG_EN       = mode_reg[BIT_WDOG_EN];
  assign WDOG_PERIOD   = {mode_reg[BIT_WDOG_PER_H], mode_reg[BIT_WDOG_PER_L]};
  assign WDOG_RST_LINK = mode_reg[BIT_RST_LINK];

  // ==========================================================================
  // Pin states
  logic [PINS-1:0] drv_data;
  logic [PINS-1:0] oe_next;
  logic [PINS-1:0] pull_next;
  logic [PINS-1:0] gate_next;
  logic            drive;

  assign drive    = mode_reg[BIT_DRIVE];
  assign drv_data = (PIN_FUNC_SEL & FUNC_DATA) | (~PIN_FUNC_SEL & PORT_DATA);
  // Floating outputs in stop unless drive bit set
  assign oe_next  = (stop_pins && !drive) ? '0 : PORT_DIR_OUT;
  // Pull direction source per pin use
  assign pull_next = ((PIN_FUNC_SEL & PORT_DIR_OUT) & FUNC_DATA) |
                     (~(PIN_FUNC_SEL & PORT_DIR_OUT) & PORT_LATCH);
  // Gate-disabled pins cut their input in stop
  assign gate_next = stop_pins ? ~GATE_DIS_MASK : '1;

  // Pins stay registered so they move with the enables, a cycle after inputs
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      PIN_O       <= '0;
      PIN_OE      <= '0;
      PIN_PULL_UP <= '0;
      PIN_IN_GATE <= '1;
    end else begin
      PIN_O       <= drv_data;
      PIN_OE      <= oe_next;
      PIN_PULL_UP <= pull_next;
      PIN_IN_GATE <= gate_next;
    end
  end

  // ==========================================================================
  // Checks
  int unsigned warm_len;
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST || state_reg != ST_WARM) begin
      warm_len <= 0;
    end else begin
      warm_len <= warm_len + 1;
    end
  end

  AST_SEL_HALT: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (state_reg == ST_RUN && HALT_EXEC && sel == SEL_HALT) |=> (state_reg == ST_HALT))
    else $error("halt field 00 did not enter halt");
  AST_SEL_STOP: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (state_reg == ST_RUN && HALT_EXEC && sel == SEL_STOP)
      |=> (state_reg == ST_ENTER)[*3] ##1 (state_reg == ST_STOP))
    else $error("field 01 did not reach stop after three entry cycles");
  AST_SEL_IDLE: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (state_reg == ST_RUN && HALT_EXEC && sel == SEL_IDLE)
      |=> ##3 (state_reg == ST_IDLE))
    else $error("field 10 did not reach idle");
  AST_HALT_EN: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (state_reg == ST_HALT) |-> (!CPU_RUN_EN && PERIPH_CLK_EN && OSC_EN))
    else $error("halt enables wrong");
  AST_IDLE_EN: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (state_reg == ST_IDLE) |-> (OSC_EN && !PERIPH_CLK_EN && !CPU_RUN_EN))
    else $error("idle enables wrong");
  AST_STOP_EN: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (state_reg == ST_STOP) |-> (!OSC_EN && !SYS_CLK_EN && !PERIPH_CLK_EN))
    else $error("stop enables wrong");
  AST_WARM_LEN: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (state_reg == ST_WARM) |-> (!SYS_CLK_EN && warm_len < warm_val))
    else $error("warm-up clock hold wrong or too long");
  AST_NO_WAKE: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (state_reg == ST_IDLE && !NMI_REQ && !EXT_WAKE) |=> (state_reg == ST_IDLE))
    else $error("idle left without a pin wake");
  AST_PEND: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (state_reg == ST_ENTER && (NMI_REQ || EXT_WAKE)) |=> pend_valid_reg)
    else $error("entry wake not held pending");
  AST_TWO_SVC: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (state_reg == ST_SVC1 && pend_valid_reg) |-> SVC_VALID ##1 SVC_VALID)
    else $error("pending request not serviced second");
  AST_RESUME: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (state_reg == ST_HALT && EXT_WAKE && !halt_ok) |=> (RESUME && !SVC_VALID))
    else $error("masked pin did not resume");
  AST_FLOAT: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (state_reg == ST_STOP && !drive && !$past(wr_take)) |-> (PIN_OE == '0))
    else $error("outputs driven in stop with drive bit clear");
endmodule
`default_nettype wire

/* smc_standby_ctrl_test.sv */
// Self-checking bench for the standby mode controller
`timescale 1ns/1ps
`default_nettype none
module smc_standby_ctrl_test;
  import smc_pkg::*;
  localparam int WS = 8;
  localparam int WL = 16;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, err, halt;
  logic        go_nmi, go_ext, go_irq, hold, nmi_req, ext_wake, irq_valid;
  logic        cpu, per, osc, sclk, svc_v, resume, wd_en, wd_link, served;
  logic [1:0]  wd_per;
  logic [2:0]  lvl, mask, ext_level, irq_level;
  logic [7:0]  paddr, pdata, dir, fsel, fdat, latch, gdis, pin_o, pin_oe, pull, gate;
  logic [31:0] pwdata, prdata, rd;
  logic [31:0] modes [2];
  smc_svc_t    svc;
  int          fails, samples_checked, n, k;

  assign served = svc_v | resume;
  smc_irq_model src (.clk(clk), .rst(rst), .go_nmi(go_nmi), .go_ext(go_ext), .go_irq(go_irq),
    .hold(hold), .lvl(lvl), .served(served), .nmi_req(nmi_req), .ext_wake(ext_wake),
    .ext_level(ext_level), .irq_valid(irq_valid), .irq_level(irq_level));
  smc_standby_ctrl #(.WARM_SHORT(WS), .WARM_LONG(WL)) dut (
    .CORE_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .HALT_EXEC(halt), .IRQ_VALID(irq_valid), .IRQ_LEVEL(irq_level), .NMI_REQ(nmi_req),
    .EXT_WAKE(ext_wake), .EXT_LEVEL(ext_level), .INT_MASK(mask), .CPU_RUN_EN(cpu),
    .PERIPH_CLK_EN(per), .OSC_EN(osc), .SYS_CLK_EN(sclk), .SVC_VALID(svc_v), .SVC(svc),
    .RESUME(resume), .WDOG_EN(wd_en), .WDOG_PERIOD(wd_per), .WDOG_RST_LINK(wd_link),
    .PORT_DATA(pdata), .PORT_DIR_OUT(dir), .PORT_LATCH(latch), .PIN_FUNC_SEL(fsel),
    .FUNC_DATA(fdat), .GATE_DIS_MASK(gdis), .PIN_O(pin_o), .PIN_OE(pin_oe),
    .PIN_PULL_UP(pull), .PIN_IN_GATE(gate));

  // ==========================================================================
  // Tasks
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic step(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  // Request held steady until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin @(posedge clk); t++; end while (pready !== 1'b1 && t < 20);
    if (pready !== 1'b1) fails++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic enter(input logic [31:0] mode);
    apb(1'b1, ADDR_MODE, mode);
    @(posedge clk) halt <= 1'b1;
    @(posedge clk) halt <= 1'b0;
    step(6);
  endtask

  task automatic fire(input logic a, input logic b, input logic c, input logic h,
                      input logic [2:0] l);
    @(posedge clk);
    go_nmi <= a; go_ext <= b; go_irq <= c; hold <= h; lvl <= l;
    @(posedge clk);
    go_nmi <= 1'b0; go_ext <= 1'b0; go_irq <= 1'b0;
  endtask

  // Bounded wait for a service or resume pulse
  task automatic wait_for(input logic sel);
    k = 0;
    do begin @(posedge clk); #1; k++; end while ((sel ? resume : svc_v) !== 1'b1 && k < 200);
    if ((sel ? resume : svc_v) !== 1'b1) fails++;
  endtask

  // ==========================================================================
  // Stimulus
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    report_and_stop();
  end

  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    halt = 1'b0; go_nmi = 1'b0; go_ext = 1'b0; go_irq = 1'b0; hold = 1'b1; lvl = 3'h0;
    mask = 3'h3; fails = 0; samples_checked = 0;
    // Pin inputs held at fixed levels through stop
    pdata = 8'h5A; dir = 8'h0F; fsel = 8'h33; fdat = 8'h05; latch = 8'hA0; gdis = 8'hC3;
    modes = '{32'h0000_0084, 32'h0000_0095};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, ADDR_MODE, 32'h0);
    check("mode reset", rd, {24'h0, MODE_RESET});
    check("gate run", gate, 8'hFF);
    apb(1'b1, ADDR_MODE, 32'hFFFF_FF62);
    apb(1'b0, ADDR_MODE, 32'h0);
    check("mode rw", rd, 32'h0000_0062);
    check("wdog bits", {wd_en, wd_per, wd_link}, 4'b0111);
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped err", err, 1'b1);
    check("unmapped rd", rd, 32'h0000_0000);
    for (int i = 0; i < 2; i++) begin
      enter(i == 0 ? 32'h0000_0080 : 32'h0000_008C);
      check("halt en", {cpu, per, osc, sclk}, 4'b0111);
      fire(1'b0, 1'b0, 1'b1, 1'b1, 3'h3);
      wait_for(1'b0);
      check("halt svc", svc, {1'b0, 3'h3});
    end
    @(posedge clk) mask <= 3'h5;
    enter(32'h0000_0080);
    fire(1'b0, 1'b0, 1'b1, 1'b1, 3'h4);
    step(4);
    check("halt masked", cpu, 1'b0);
    fire(1'b0, 1'b1, 1'b0, 1'b1, 3'h1);
    wait_for(1'b1);
    check("resume", {resume, svc_v}, 2'b10);
    @(posedge clk) mask <= 3'h2;
    enter(32'h0000_0088);
    check("idle en", {cpu, per, osc, sclk}, 4'b0010);
    fire(1'b0, 1'b0, 1'b1, 1'b1, 3'h7);
    step(4);
    check("idle irq", cpu, 1'b0);
    fire(1'b0, 1'b1, 1'b0, 1'b1, 3'h1);
    step(4);
    check("idle low ext", cpu, 1'b0);
    fire(1'b0, 1'b1, 1'b0, 1'b1, 3'h2);
    wait_for(1'b0);
    check("idle svc", svc, {1'b0, 3'h2});
    for (int i = 0; i < 2; i++) begin
      enter(modes[i]);
      check("stop en", {cpu, per, osc, sclk}, 4'b0000);
      check("stop oe", pin_oe, modes[i][0] ? dir : 8'h00);
      check("stop out", pin_o, 8'h49);
      check("stop pull", pull, 8'hA1);
      check("stop gate", gate, 8'h3C);
      fire(1'b1, 1'b0, 1'b0, 1'b1, 3'h0);
      n = 0;
      k = 0;
      do begin @(posedge clk); #1; k++; if (osc && !sclk) n++; end
      while (svc_v !== 1'b1 && k < 100);
      check("warm", n, modes[i][4] ? WL : WS);
      check("stop svc", svc, {1'b1, NMI_LEVEL});
    end
    // Glitch on the wake pin while the stop entry is under way
    @(posedge clk) mask <= 3'h0;
    apb(1'b1, ADDR_MODE, 32'h0000_0084);
    @(posedge clk) halt <= 1'b1;
    @(posedge clk);
    halt <= 1'b0; go_ext <= 1'b1; hold <= 1'b0; lvl <= 3'h2;
    @(posedge clk) go_ext <= 1'b0;
    step(6);
    check("pend no wake", {cpu, osc}, 2'b00);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check("pend status", rd, 32'h0000_004C);
    fire(1'b1, 1'b0, 1'b0, 1'b1, 3'h0);
    wait_for(1'b0);
    check("pend first", svc, {1'b1, NMI_LEVEL});
    step(1);
    check("pend second", {svc_v, svc}, {1'b1, 1'b0, 3'h2});
    enter(32'h0000_0084);
    // Long reset covers oscillator start, no warm-up applies
    @(posedge clk) rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    step(1);
    check("reset wake", {cpu, per, osc, sclk}, 4'b1111);
    report_and_stop();
  end
endmodule
`default_nettype wire
